// [core/cpm_pkg.sv]
// Constants and types of the core programming model block
package cpm_pkg;
   // Register word indices, byte address is four times the index
   localparam logic [4:0] IDX_D0    = 5'h00; // Data registers 0..7
   localparam logic [4:0] IDX_A0    = 5'h08; // Address registers 8..15
   localparam logic [4:0] IDX_SR    = 5'h10; // Status word
   localparam logic [4:0] IDX_VBR   = 5'h11; // Exception table base
   localparam logic [4:0] IDX_CACHE_CONFIG_REG  = 5'h12; // Cache configuration
   localparam logic [4:0] IDX_ACR0  = 5'h13; // Region attributes 0..3
   localparam logic [4:0] IDX_RAM0  = 5'h17; // SRAM bases 0..1
   localparam logic [4:0] IDX_PERIPHERAL_BASE_REG  = 5'h19; // Peripheral base
   localparam logic [4:0] IDX_MASK  = 5'h1a; // MAC address mask
   localparam logic [4:0] IDX_PC    = 5'h1b; // Program counter
   localparam logic [4:0] IDX_OP    = 5'h1c; // Operation launch
   localparam logic [4:0] IDX_EA    = 5'h1d; // Effective address
   localparam logic [4:0] IDX_STK   = 5'h1e; // Stacked status word
   localparam logic [4:0] IDX_SDAT  = 5'h1f; // Store data
   // Status word fields
   localparam int SR_S  = 13; // Privilege bit
   localparam int CC_X  = 4;
   localparam int CC_N  = 3;
   localparam int CC_Z  = 2;
   localparam int CC_V  = 1;
   localparam int CC_C  = 0;
   localparam logic [15:0] SR_RST   = 16'h2700;
   localparam logic [31:0] VBR_KEEP = 32'hfff0_0000;
   localparam logic [31:0] SAT_POS  = 32'h7fff_ffff;
   localparam logic [31:0] SAT_NEG  = 32'h8000_0000;
   localparam logic [31:0] STK_STEP = 32'h0000_0004;
   localparam logic [7:0]  VEC_PRIV = 8'h08;
   localparam logic [7:0]  VEC_TRAP = 8'h20;
   localparam logic [7:0]  TAS_BIT  = 8'h80;
   // Operand sizes
   localparam logic [1:0] SZ_B = 2'h0;
   localparam logic [1:0] SZ_W = 2'h1;
   localparam logic [1:0] SZ_L = 2'h2;
   // Operation codes in the launch word
   typedef enum logic [3:0] {
      OP_MOVQ, OP_MVS, OP_MVZ, OP_SATS, OP_TAS, OP_CMP, OP_BRA,
      OP_BSR, OP_MOVI, OP_MACLD, OP_RTE, OP_TRAP, OP_SRMV
   } cpm_op_t;
   // Launch word layout
   typedef struct packed {
      logic [15:0] disp; // Displacement
      logic        mske; // Apply MAC mask
      logic [2:0]  imm;  // Quick immediate
      logic [2:0]  src;  // First operand
      logic [2:0]  dst;  // Second operand
      logic [1:0]  sz;   // Size
      logic [3:0]  code; // Operation
   } cpm_opw_t;
   // Whole state of the block
   typedef struct packed {
      logic [7:0][31:0] d;
      logic [7:0][31:0] a;
      logic [15:0]      sr;
      logic [31:0]      exception_table_base;
      logic [31:0]      cache_config_reg;
      logic [3:0][31:0] acr;
      logic [1:0][31:0] ram;
      logic [31:0]      peripheral_base_reg;
      logic [31:0]      mask;
      logic [31:0]      pc;
      logic [31:0]      ea;
      logic [15:0]      stk;
      logic [31:0]      sdat;
      logic [31:0]      rdata;
      logic             err;
   } cpm_state_t;
endpackage : cpm_pkg

// [core/cpm_core.sv]
// Programming model register file with operation unit and APB slave
//
// Notes on behaviour
// - User mode restricts registers, refuses privileged ops
// - Return restores privilege bit from stacked word
// - Supervisor mode reaches every register and op
// - Every exception enters supervisor mode
// - Eight 32-bit data registers, sized operands
// - Eight address registers, eighth is stack pointer
// - Condition flags are the status low byte
// - Status upper byte writable only in supervisor
// - Exception base keeps 12 bits, low 20 zero
// - Four region registers, two data, two fetch
// - Two SRAM base registers
// - One peripheral base register
// - Mask optionally limits MAC operand addresses
// - Quick move writes 3-bit immediate longword
// - Sign-extending move widens byte or word
// - Zero-extending move fills upper bits
// - Saturate sets destination from overflow flag
// - Test-and-set flags byte then sets it
// - Branches accept longword displacements
// - Compare supports byte, word, longword
// - Immediate store to displaced address: byte, long
// - First operand source, second destination
//
// Local design decisions: the register offsets and register access over APB.
module cpm_core
   import cpm_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Status
   output logic                   supervisor
);
   ////////////////////////////////////////////////////////////////
   // Helpers
   // Extend a sized operand to 32 bits
   function automatic logic [31:0] ext(input logic [31:0] v,
                                       input logic [1:0] sz,
                                       input logic sgn);
      case (sz)
         SZ_B:    ext = {{24{sgn & v[7]}}, v[7:0]};
         SZ_W:    ext = {{16{sgn & v[15]}}, v[15:0]};
         default: ext = v;
      endcase
   endfunction : ext

   // Left-justify a sized operand so its sign is bit 31
   function automatic logic [31:0] ljust(input logic [31:0] v,
                                         input logic [1:0] sz);
      case (sz)
         SZ_B:    ljust = {v[7:0], 24'h00_0000};
         SZ_W:    ljust = {v[15:0], 16'h0000};
         default: ljust = v;
      endcase
   endfunction : ljust

   // Supervisor-only register indices
   function automatic logic sup_only(input logic [4:0] idx);
      sup_only = (idx >= IDX_VBR && idx <= IDX_PERIPHERAL_BASE_REG) || idx == IDX_STK;
   endfunction : sup_only

   ////////////////////////////////////////////////////////////////
   // State
   cpm_state_t r_reg;   // Registered state
   cpm_state_t r_next;  // Next state
   logic [4:0] idx;     // Word index
   logic       mapped;  // Upper address bits clear
   logic       setup;   // APB setup phase
   logic       wr;      // Accepted write
   cpm_opw_t   opw;     // Launch word
   logic [31:0] ls, ld, df;
   logic        bo;
   logic [31:0] disp;
   logic        sup;

   assign idx    = paddr[6:2];
   assign mapped = (paddr >> 7) == '0;
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite & ~r_reg.err;
   assign opw    = pwdata;
   assign sup    = r_reg.sr[SR_S];

   // Outputs
   assign prdata     = r_reg.rdata;
   assign pready     = 1'b1;
   assign pslverr    = penable & r_reg.err;
   assign supervisor = sup;

   ////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      r_next = r_reg;
      // Sized compare, first operand subtracted from second
      ls = ljust(r_reg.d[opw.src], opw.sz);
      ld = ljust(r_reg.d[opw.dst], opw.sz);
      {bo, df} = {1'b0, ld} - {1'b0, ls};
      // Branch displacement, longword taken from a data register
      if (opw.sz == SZ_L) begin
         disp = r_reg.d[opw.src];
      end else begin
         disp = ext({16'h0000, opw.disp}, opw.sz, 1'b1);
      end
      // Setup phase latches read data and error
      if (setup) begin
         r_next.err = ~mapped | (~sup & sup_only(idx));
         if (idx < IDX_A0) begin
            r_next.rdata = r_reg.d[idx[2:0]];
         end else if (idx < IDX_SR) begin
            r_next.rdata = r_reg.a[idx[2:0]];
         end else begin
            case (idx)
               IDX_SR:   r_next.rdata = {16'h0000, sup ? r_reg.sr : {8'h00, r_reg.sr[7:0]}};
               IDX_VBR:  r_next.rdata = r_reg.exception_table_base;
               IDX_CACHE_CONFIG_REG: r_next.rdata = r_reg.cache_config_reg;
               IDX_PERIPHERAL_BASE_REG: r_next.rdata = r_reg.peripheral_base_reg;
               IDX_MASK: r_next.rdata = r_reg.mask;
               IDX_PC:   r_next.rdata = r_reg.pc;
               IDX_EA:   r_next.rdata = r_reg.ea;
               IDX_STK:  r_next.rdata = {16'h0000, r_reg.stk};
               IDX_SDAT: r_next.rdata = r_reg.sdat;
               default: begin
                  if (idx >= IDX_ACR0 && idx < IDX_RAM0) begin
                     r_next.rdata = r_reg.acr[2'(idx - IDX_ACR0)];
                  end else if (idx == IDX_RAM0 || idx == IDX_RAM0 + 5'h01) begin
                     r_next.rdata = r_reg.ram[idx[0] ^ IDX_RAM0[0]];
                  end else begin
                     r_next.rdata = '0;
                  end
               end
            endcase
         end
      end
      // Register writes at the access edge
      if (wr) begin
         if (idx < IDX_A0) begin
            r_next.d[idx[2:0]] = pwdata;
         end else if (idx < IDX_SR) begin
            r_next.a[idx[2:0]] = pwdata;
         end else begin
            case (idx)
               // User writes reach only the flag byte
               IDX_SR: begin
                  r_next.sr[7:0] = pwdata[7:0];
                  if (sup) begin
                     r_next.sr[15:8] = pwdata[15:8];
                  end
               end
               IDX_VBR:  r_next.exception_table_base  = pwdata & VBR_KEEP;
               IDX_CACHE_CONFIG_REG: r_next.cache_config_reg = pwdata;
               IDX_PERIPHERAL_BASE_REG: r_next.peripheral_base_reg = pwdata;
               IDX_MASK: r_next.mask = pwdata;
               IDX_PC:   r_next.pc   = pwdata;
               IDX_STK:  r_next.stk  = pwdata[15:0];
               IDX_OP: begin
                  // Privileged op from user mode traps instead
                  if (~sup && (opw.code == OP_RTE || opw.code == OP_SRMV)) begin
                     r_next.stk = r_reg.sr;
                     r_next.sr[SR_S] = 1'b1;
                     r_next.a[7] = r_reg.a[7] - STK_STEP;
                     r_next.pc = r_reg.exception_table_base | {22'h00_0000, VEC_PRIV, 2'b00};
                  end else begin
                     case (opw.code)
                        OP_MOVQ: r_next.d[opw.dst] = {29'h0000_0000, opw.imm};
                        OP_MVS:  r_next.d[opw.dst] = ext(r_reg.d[opw.src], opw.sz, 1'b1);
                        OP_MVZ:  r_next.d[opw.dst] = ext(r_reg.d[opw.src], opw.sz, 1'b0);
                        OP_SATS: begin
                           if (r_reg.sr[CC_V]) begin
                              r_next.d[opw.dst] = r_reg.d[opw.dst][31] ? SAT_POS : SAT_NEG;
                           end
                        end
                        OP_TAS: begin
                           r_next.sr[CC_N] = r_reg.d[opw.dst][7];
                           r_next.sr[CC_Z] = r_reg.d[opw.dst][7:0] == 8'h00;
                           r_next.sr[CC_V] = 1'b0;
                           r_next.sr[CC_C] = 1'b0;
                           r_next.d[opw.dst][7:0] = r_reg.d[opw.dst][7:0] | TAS_BIT;
                        end
                        OP_CMP: begin
                           r_next.sr[CC_N] = df[31];
                           r_next.sr[CC_Z] = df == '0;
                           r_next.sr[CC_V] = (ld[31] ^ ls[31]) & (ld[31] ^ df[31]);
                           r_next.sr[CC_C] = bo;
                        end
                        OP_BRA: r_next.pc = r_reg.pc + disp;
                        OP_BSR: begin
                           r_next.a[7] = r_reg.a[7] - STK_STEP;
                           r_next.sdat = r_reg.pc;
                           r_next.pc = r_reg.pc + disp;
                        end
                        OP_MOVI: begin
                           if (opw.sz != SZ_W) begin
                              r_next.ea = r_reg.a[opw.dst] + ext({16'h0000, opw.disp}, SZ_W, 1'b1);
                              r_next.sdat = ext(r_reg.d[opw.src], opw.sz, 1'b0);
                           end
                        end
                        OP_MACLD: begin
                           r_next.ea = opw.mske ? (r_reg.a[opw.src] & r_reg.mask) : r_reg.a[opw.src];
                        end
                        OP_RTE: begin
                           r_next.sr = r_reg.stk;
                           r_next.a[7] = r_reg.a[7] + STK_STEP;
                        end
                        OP_TRAP: begin
                           r_next.stk = r_reg.sr;
                           r_next.sr[SR_S] = 1'b1;
                           r_next.a[7] = r_reg.a[7] - STK_STEP;
                           r_next.pc = r_reg.exception_table_base | {22'h00_0000, VEC_TRAP, 2'b00};
                        end
                        OP_SRMV: r_next.sr = r_reg.d[opw.src][15:0];
                        default: r_next.sdat = r_reg.sdat;
                     endcase
                  end
               end
               default: begin
                  // Region and SRAM base registers
                  if (idx >= IDX_ACR0 && idx < IDX_RAM0) begin
                     r_next.acr[2'(idx - IDX_ACR0)] = pwdata;
                  end else if (idx == IDX_RAM0 || idx == IDX_RAM0 + 5'h01) begin
                     r_next.ram[idx[0] ^ IDX_RAM0[0]] = pwdata;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_reg    <= '0;
         r_reg.sr <= SR_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic op_wr;
   assign op_wr = wr && idx == IDX_OP;

   sequence user_priv_s;
      op_wr && !sup && (opw.code == OP_RTE || opw.code == OP_SRMV);
   endsequence

   user_trap_a: assert property (user_priv_s |=> sup && r_reg.stk == $past(r_reg.sr))
      else $error("user privileged op did not trap");
   trap_entry_a: assert property (op_wr && opw.code == OP_TRAP |=> sup)
      else $error("exception did not enter supervisor");
   rte_restore_a: assert property (op_wr && sup && opw.code == OP_RTE
                                   |=> sup == $past(r_reg.stk[SR_S]))
      else $error("return did not restore privilege");
   user_reject_a: assert property (setup && mapped && !sup && sup_only(idx) ##1 penable
                                   |-> pslverr)
      else $error("user access not refused");
   sr_upper_a: assert property (wr && idx == IDX_SR && !sup
                                |=> r_reg.sr[15:8] == $past(r_reg.sr[15:8]))
      else $error("user changed upper status byte");
   vbr_zero_a: assert property (r_reg.exception_table_base[19:0] == '0)
      else $error("exception base low bits set");
   quick_move_a: assert property (op_wr && sup && opw.code == OP_MOVQ
                                  |=> r_reg.d[$past(opw.dst)] == 32'($past(opw.imm)))
      else $error("quick move wrong value");
   tas_set_a: assert property (op_wr && opw.code == OP_TAS |=> r_reg.d[$past(opw.dst)][7])
      else $error("test-and-set left byte clear");
endmodule : cpm_core

// [bench/cpm_core_tb.sv]
// Self-checking testbench of the programming model register file over APB
module cpm_core_tb
   import cpm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // Design signals
   logic        clk_sys = 1'b0; // 20 MHz clock
   logic        rst;            // Synchronous reset
   logic        psel;           // APB select
   logic        penable;        // APB access phase
   logic        pwrite;         // APB direction
   logic [11:0] paddr;          // APB byte address
   logic [31:0] pwdata;         // APB write data
   logic [31:0] prdata;         // APB read data
   logic        pready;         // APB ready
   logic        pslverr;        // APB error
   logic        supervisor;     // Privilege level
   logic [31:0] rdat;           // Last read data
   logic        rerr;           // Last error response
   int          fail_count = 0; // Mismatches
   int          n_checks = 0;   // Comparisons
   int          cycles = 0;     // Timeout counter

   cpm_core dut (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .supervisor (supervisor)
   );

   // Clock of 50 ns period
   always #25 clk_sys = ~clk_sys;

   // Hang guard, far above the length of the sequence
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Privilege level, looked at mid-cycle once the write edge has settled
   task automatic chk_sup(input logic exp);
      @(negedge clk_sys);
      chk({31'h0, supervisor}, {31'h0, exp});
   endtask : chk_sup

   ////////////////////////////////////////////////////////////////////////////
   // APB master: one idle edge, setup, access held until pready
   task automatic apb(input logic wr, input logic [4:0] idx, input logic [31:0] wd, input logic [4:0] hi);
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {hi, idx, 2'b00};
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd, 5'h00);
   endtask : wr

   task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000, 5'h00);
      chk(rdat, exp);
   endtask : rd

   // Launch one operation through the launch word
   task automatic op(input cpm_op_t c, input logic [1:0] s, input logic [2:0] d, src, imm,
                     input logic [15:0] disp);
      cpm_opw_t w;
      w = '{disp: disp, mske: 1'b0, imm: imm, src: src, dst: d, sz: s, code: c};
      wr(IDX_OP, w);
   endtask : op

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset state is supervisor
      rd(IDX_SR, 32'h0000_2700);
      chk_sup(1'b1);
      // Sixteen general registers hold full words
      for (int i = 0; i < 16; i++) wr(5'(i), 32'h5a00_0000 | 32'(i));
      for (int i = 0; i < 16; i++) rd(5'(i), 32'h5a00_0000 | 32'(i));
      // Configuration registers from cache configuration to MAC mask store their words
      for (int i = 18; i < 27; i++) wr(5'(i), 32'h1234_5600 | 32'(i));
      for (int i = 18; i < 27; i++) rd(5'(i), 32'h1234_5600 | 32'(i));
      // Exception base keeps only upper 12 bits
      wr(IDX_VBR, 32'hffff_ffff);
      rd(IDX_VBR, 32'hfff0_0000);
      wr(5'h0f, 32'h0000_0100);
      // Quick move, sign and zero extension, source untouched
      op(OP_MOVQ, SZ_L, 3'd1, 3'd0, 3'd5, 16'h0000);
      rd(5'h01, 32'h0000_0005);
      wr(5'h02, 32'h1234_8081);
      op(OP_MVS, SZ_B, 3'd3, 3'd2, 3'd0, 16'h0000);
      op(OP_MVZ, SZ_W, 3'd4, 3'd2, 3'd0, 16'h0000);
      rd(5'h03, 32'hffff_ff81);
      rd(5'h04, 32'h0000_8081);
      rd(5'h02, 32'h1234_8081);
      // Saturate with overflow flag set
      wr(IDX_SR, 32'h0000_2702);
      wr(5'h05, 32'h0000_0005);
      op(OP_SATS, SZ_L, 3'd5, 3'd0, 3'd0, 16'h0000);
      rd(5'h05, 32'h8000_0000);
      // Test-and-set sets bit 7 and clears flags
      wr(5'h06, 32'h0000_0012);
      op(OP_TAS, SZ_B, 3'd6, 3'd0, 3'd0, 16'h0000);
      rd(5'h06, 32'h0000_0092);
      rd(IDX_SR, 32'h0000_2700);
      // Byte compare sees equal low bytes only
      wr(5'h00, 32'h0000_0155);
      wr(5'h07, 32'hff00_0055);
      op(OP_CMP, SZ_B, 3'd0, 3'd7, 3'd0, 16'h0000);
      rd(IDX_SR, 32'h0000_2704);
      // Long branch then subroutine call on the stack pointer
      wr(IDX_PC, 32'h0000_1000);
      wr(5'h01, 32'h0000_0200);
      op(OP_BRA, SZ_L, 3'd0, 3'd1, 3'd0, 16'h0000);
      rd(IDX_PC, 32'h0000_1200);
      op(OP_BSR, SZ_W, 3'd0, 3'd0, 3'd0, 16'h0010);
      rd(IDX_PC, 32'h0000_1210);
      rd(IDX_SDAT, 32'h0000_1200);
      rd(5'h0f, 32'h0000_00fc);
      // Immediate store to displaced address, byte and long
      wr(5'h09, 32'h0000_2000);
      op(OP_MOVI, SZ_B, 3'd1, 3'd2, 3'd0, 16'hfff0);
      rd(IDX_EA, 32'h0000_1ff0);
      rd(IDX_SDAT, 32'h0000_0081);
      op(OP_MOVI, SZ_L, 3'd1, 3'd2, 3'd0, 16'h0004);
      rd(IDX_SDAT, 32'h1234_8081);
      // MAC operand address with and without the mask
      wr(5'h09, 32'h0000_2345);
      wr(IDX_MASK, 32'h0000_0ff0);
      wr(IDX_OP, {16'h0000, 1'b1, 3'd0, 3'd1, 3'd0, SZ_L, 4'(OP_MACLD)});
      rd(IDX_EA, 32'h0000_0340);
      op(OP_MACLD, SZ_L, 3'd0, 3'd1, 3'd0, 16'h0000);
      rd(IDX_EA, 32'h0000_2345);
      // Drop to user mode, upper status byte then locked
      wr(IDX_SR, 32'h0000_0000);
      chk_sup(1'b0);
      wr(IDX_SR, 32'h0000_2700);
      chk_sup(1'b0);
      rd(IDX_SR, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0000);
      apb(1'b1, IDX_VBR, 32'h0000_0000, 5'h00);
      chk({31'h0, rerr}, 32'h0000_0001);
      // Privileged return in user mode traps
      op(OP_RTE, SZ_L, 3'd0, 3'd0, 3'd0, 16'h0000);
      chk_sup(1'b1);
      rd(IDX_PC, 32'hfff0_0020);
      rd(IDX_STK, 32'h0000_0000);
      rd(IDX_VBR, 32'hfff0_0000);
      // Return restores the stacked user level
      op(OP_RTE, SZ_L, 3'd0, 3'd0, 3'd0, 16'h0000);
      chk_sup(1'b0);
      // Trap from user enters supervisor
      op(OP_TRAP, SZ_L, 3'd0, 3'd0, 3'd0, 16'h0000);
      chk_sup(1'b1);
      rd(IDX_PC, 32'hfff0_0080);
      rd(5'h0f, 32'h0000_00f8);
      // Status move runs in supervisor and traps in user
      wr(5'h00, 32'h0000_0004);
      op(OP_SRMV, SZ_L, 3'd0, 3'd0, 3'd0, 16'h0000);
      chk_sup(1'b0);
      rd(IDX_SR, 32'h0000_0004);
      op(OP_SRMV, SZ_L, 3'd0, 3'd0, 3'd0, 16'h0000);
      chk_sup(1'b1);
      rd(IDX_STK, 32'h0000_0004);
      rd(IDX_SR, 32'h0000_2004);
      rd(5'h0f, 32'h0000_00f4);
      // Unmapped address is refused
      apb(1'b0, IDX_D0, 32'h0000_0000, 5'h01);
      chk({31'h0, rerr}, 32'h0000_0001);
      give_verdict();
   end
endmodule : cpm_core_tb
